/* hw/ict_pkg.sv */
package ict_pkg;
    // =========================================================
    // Instruction word layout
    // =========================================================
    localparam int          ICT_WORD_W      = 24;    // One program word
    localparam int          ICT_DWORD_BITS  = 48;    // Two words together
    localparam int          ICT_OPC_W       = 8;     // Upper opcode byte width
    localparam int          ICT_OPC_LSB     = 16;    // Opcode byte position
    localparam logic [7:0]  ICT_SECOND_TAG  = 8'h00; // Upper byte of a second word

    // =========================================================
    // Instruction classes supplied by the decoder
    // =========================================================
    typedef enum logic [2:0] {
        ICT_CLS_PLAIN   = 3'h0, // Ordinary single-word operation
        ICT_CLS_FLOW    = 3'h1, // Branch, computed jump, indirect call or jump
        ICT_CLS_TABLE   = 3'h2, // Table read or write
        ICT_CLS_RETURN  = 3'h3, // Subroutine or interrupt return
        ICT_CLS_SKIP    = 3'h4, // Conditional skip
        ICT_CLS_DOUBLE  = 3'h5, // Two-word instruction
        ICT_CLS_DMOVE   = 3'h6  // Two-word data move
    } ict_cls_type;

    // =========================================================
    // Cycle counts
    // =========================================================
    localparam logic [1:0]  ICT_CYC_ONE     = 2'h1;
    localparam logic [1:0]  ICT_CYC_TWO     = 2'h2;
    localparam logic [1:0]  ICT_CYC_THREE   = 2'h3;
endpackage

/* hw/ict_word_class.sv */
`timescale 1ns/10ps
`default_nettype none
// =========================================================
// Combinational check for a second word of a pair
// =========================================================
module ict_word_class (
    input  wire logic [ict_pkg::ICT_WORD_W-1:0] i_word,
    output logic                                o_is_second
);
    import ict_pkg::*;

    // Upper byte all zero marks an operand-only word
    always_comb begin
        o_is_second = (i_word[ICT_OPC_LSB +: ICT_OPC_W] == ICT_SECOND_TAG);
    end
endmodule
`default_nettype wire

/* hw/ict_cycle_ctrl.sv */
// Notes on behaviour
// - Gather both words of 48-bit instructions
// - Second word has upper eight bits zero
// - Lone second word executes as no-operation
// - Double-word instructions take exactly two cycles
// - Taken condition or PC change adds nop
// - Flow, table, return ops take two/three cycles
// - Taken skip costs two or three by skipped size
// - Double-word moves always take two cycles
`timescale 1ns/10ps
`default_nettype none
module ict_cycle_ctrl (
    // Clock and asynchronous active-low reset
    input  wire logic                               i_clk,
    input  wire logic                               i_nrst,
    // Fetch side, one word per instruction cycle
    input  wire logic                               i_word_valid,
    input  wire logic [ict_pkg::ICT_WORD_W-1:0]     i_word,
    // Decoder hints, sampled with the word they describe
    input  wire ict_pkg::ict_cls_type               i_cls,
    input  wire logic                               i_cond_true,
    input  wire logic                               i_pc_change,
    input  wire logic                               i_long_form,
    input  wire logic                               i_next_double,
    // Execute side
    output logic                                    o_word_ready,
    output logic                                    o_exec_valid,
    output logic [ict_pkg::ICT_DWORD_BITS-1:0]      o_exec_bits,
    output logic                                    o_exec_nop,
    output logic [1:0]                              o_exec_cycles,
    output logic                                    o_busy
);
    import ict_pkg::*;

    // Limitation: the class of each word comes from an outside decoder;
    // this block only counts cycles and never looks at opcode fields
    // beyond the zero marker of a second word.

    // =========================================================
    // Elaboration checks
    // =========================================================
    // The completed instruction is exactly two program words
    if (ICT_DWORD_BITS != ICT_WORD_W + ICT_WORD_W) begin : g_bad_pair
        $error("completed instruction must hold two program words");
    end

    // The zero marker must be the top byte of a word
    if (ICT_OPC_LSB + ICT_OPC_W != ICT_WORD_W) begin : g_bad_marker
        $error("second-word marker must sit in the top byte");
    end

    // The marker value must be as wide as the field it matches
    if ($bits(ICT_SECOND_TAG) != ICT_OPC_W) begin : g_bad_tag
        $error("second-word marker value differs in width from its field");
    end

    // Cycle counts must rise from one to three
    if (!(ICT_CYC_ONE < ICT_CYC_TWO && ICT_CYC_TWO < ICT_CYC_THREE)) begin : g_bad_cycles
        $error("cycle count constants out of order");
    end

    // =========================================================
    // State
    // =========================================================
    // Plain binary codes; the stall length lives in its own counter
    typedef enum logic [1:0] {
        ICT_ST_FETCH  = 2'b00, // Waiting for a first word
        ICT_ST_SECOND = 2'b01, // Gathering second word
        ICT_ST_STALL  = 2'b10  // Burning no-operation cycles
    } ict_state_type;

    // Trade-off: the first word is held whole rather than only its operand
    // bits, so a pair leaves exactly as it arrived
    typedef struct packed {
        ict_state_type              st;         // Sequencer state
        logic [1:0]                 left;       // Remaining stall cycles
        logic [ICT_WORD_W-1:0]      first;      // Held first word
        logic [1:0]                 cycles;     // Cycles of current instr
        logic                       ex_valid;   // Completion pulse
        logic [ICT_DWORD_BITS-1:0]  ex_bits;    // Completed bits
        logic                       ex_nop;     // Completion is a nop
        logic [1:0]                 ex_cycles;  // Reported cycle count
    } ict_regs_type;

    // Whole state kept in one register and its next copy
    ict_regs_type  r_q;   // Registered state
    ict_regs_type  r_d;   // Next state
    logic          is_second; // Word looks like an operand word

    // =========================================================
    // Second-word recogniser
    // =========================================================
    // Kept apart so a real opcode decoder can reuse the same test
    ict_word_class u_class (
        .i_word      (i_word),
        .o_is_second (is_second)
    );

    // =========================================================
    // Cycle cost of a single word
    // =========================================================
    // Total cycles for a single-word instruction
    // Pairs never come here; they are counted on the pair path
    function automatic logic [1:0] ict_single_cost(input ict_cls_type cls, input logic cond,
                                                  input logic pcchg, input logic longf,
                                                  input logic nxt2);
        logic [1:0] c;
        c = ICT_CYC_ONE;
        case (cls)
            ICT_CLS_FLOW, ICT_CLS_TABLE, ICT_CLS_RETURN: begin
                c = longf ? ICT_CYC_THREE : ICT_CYC_TWO;
            end
            ICT_CLS_SKIP: begin
                // A skip that falls through costs its own cycle only
                if (cond) begin
                    c = nxt2 ? ICT_CYC_THREE : ICT_CYC_TWO;
                end
            end
            default: begin
                // Taken test or program counter change adds one nop
                if (cond || pcchg) begin
                    c = ICT_CYC_TWO;
                end
            end
        endcase
        return c;
    endfunction

    // =========================================================
    // Next-state logic
    // =========================================================
    // FETCH takes first words and single words, SECOND completes a
    // pair, STALL burns the no-operation cycles a single word owes.
    // The exec pulse is cleared by default so it stands one cycle.
    always_comb begin
        r_d          = r_q;
        r_d.ex_valid = 1'b0;
        case (r_q.st)
            ICT_ST_FETCH: begin
                if (i_word_valid) begin
                    if (is_second) begin
                        // Orphan operand word, no side effects
                        // It never stalls: the orphan costs only its own fetch
                        r_d.ex_valid  = 1'b1;
                        r_d.ex_nop    = 1'b1;
                        r_d.ex_bits   = '0;
                        r_d.ex_cycles = ICT_CYC_ONE;
                    end else if (i_cls == ICT_CLS_DOUBLE || i_cls == ICT_CLS_DMOVE) begin
                        // Hold first half until its partner arrives
                        r_d.first  = i_word;
                        r_d.cycles = ICT_CYC_TWO;
                        r_d.st     = ICT_ST_SECOND;
                    end else begin
                        // Cost decided now, the stall burns the rest
                        r_d.cycles    = ict_single_cost(i_cls, i_cond_true, i_pc_change,
                                                        i_long_form, i_next_double);
                        r_d.ex_valid  = 1'b1;
                        r_d.ex_nop    = 1'b0;
                        r_d.ex_bits   = {{ICT_WORD_W{1'b0}}, i_word};
                        r_d.ex_cycles = r_d.cycles;
                        if (r_d.cycles != ICT_CYC_ONE) begin
                            r_d.left = r_d.cycles - ICT_CYC_ONE;
                            r_d.st   = ICT_ST_STALL;
                        end
                    end
                end
            end
            ICT_ST_SECOND: begin
                if (i_word_valid) begin
                    // Class hints of the second word are ignored on purpose
                    // Always two cycles, whatever the operand form
                    r_d.ex_valid  = 1'b1;
                    r_d.ex_nop    = 1'b0;
                    r_d.ex_bits   = {r_q.first, i_word};
                    r_d.ex_cycles = r_q.cycles;
                    r_d.st        = ICT_ST_FETCH;
                end
            end
            ICT_ST_STALL: begin
                // Added cycles execute as no-operation
                // Offers are refused here, so upstream holds its word
                r_d.left = r_q.left - ICT_CYC_ONE;
                if (r_q.left == ICT_CYC_ONE) begin
                    r_d.st = ICT_ST_FETCH;
                end
            end
            default: begin
                // Unused code: fall back to fetching
                r_d.st = ICT_ST_FETCH;
            end
        endcase
    end

    // =========================================================
    // State register
    // =========================================================
    // Asynchronous clear to the idle fetch state
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Constants only; ready reads high straight out of reset
            r_q <= '{st:        ICT_ST_FETCH,
                     left:      '0,
                     first:     '0,
                     cycles:    '0,
                     ex_valid:  1'b0,
                     ex_bits:   '0,
                     ex_nop:    1'b0,
                     ex_cycles: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // Fetch is refused while burning stall cycles; kept combinational
    // so the very next offer after a costly single is held back
    assign o_word_ready  = (r_q.st != ICT_ST_STALL);
    // Completion record, all straight from flip-flops
    assign o_exec_valid  = r_q.ex_valid;
    assign o_exec_bits   = r_q.ex_bits;
    assign o_exec_nop    = r_q.ex_nop;
    assign o_exec_cycles = r_q.ex_cycles;
    assign o_busy        = (r_q.st != ICT_ST_FETCH);
endmodule
`default_nettype wire

/* test/ict_checks_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Cycle accounting seen at the ports
module ict_checks
    import ict_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_word_valid,
    input wire logic [23:0] i_word,
    input wire ict_cls_type i_cls,
    input wire logic        i_cond_true,
    input wire logic        i_pc_change,
    input wire logic        i_long_form,
    input wire logic        i_next_double,
    input wire logic        o_word_ready,
    input wire logic        o_exec_valid,
    input wire logic [47:0] o_exec_bits,
    input wire logic        o_exec_nop,
    input wire logic [1:0]  o_exec_cycles,
    input wire logic        o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire t1 = i_word_valid && o_word_ready && !o_busy; // First word taken
    wire lone = i_word[23:16] == 8'h00;                // Looks like a second word
    property p_orph; t1 && lone |=> o_exec_valid && o_exec_nop && o_exec_cycles == 2'h1 && o_exec_bits == '0; endproperty
    a_orph: assert property (p_orph) else $error("orphan word not a nop");
    property p_dbl1; t1 && !lone && i_cls inside {ICT_CLS_DOUBLE, ICT_CLS_DMOVE} |=> o_busy && !o_exec_valid; endproperty
    a_dbl1: assert property (p_dbl1) else $error("pair not gathered");
    property p_dbl2; i_word_valid && o_word_ready && o_busy |=> o_exec_valid && o_exec_cycles == 2'h2 && !o_exec_nop
        && o_exec_bits[23:0] == $past(i_word); endproperty
    a_dbl2: assert property (p_dbl2) else $error("pair result wrong");
    property p_plain; t1 && !lone && i_cls == ICT_CLS_PLAIN |=> o_exec_valid
        && o_exec_cycles == (($past(i_cond_true) || $past(i_pc_change)) ? 2'h2 : 2'h1); endproperty
    a_plain: assert property (p_plain) else $error("plain cycles wrong");
    property p_flow; t1 && !lone && i_cls inside {ICT_CLS_FLOW, ICT_CLS_TABLE, ICT_CLS_RETURN}
        |=> o_exec_cycles == ($past(i_long_form) ? 2'h3 : 2'h2); endproperty
    a_flow: assert property (p_flow) else $error("flow cycles wrong");
    property p_skip; t1 && !lone && i_cls == ICT_CLS_SKIP
        |=> o_exec_cycles == (!$past(i_cond_true) ? 2'h1 : $past(i_next_double) ? 2'h3 : 2'h2); endproperty
    a_skip: assert property (p_skip) else $error("skip cycles wrong");
    property p_st2; o_exec_valid && o_busy && o_exec_cycles == 2'h2 |-> !o_word_ready ##1 o_word_ready; endproperty
    a_st2: assert property (p_st2) else $error("two cycle stall wrong");
    property p_st3; o_exec_valid && o_busy && o_exec_cycles == 2'h3 |-> !o_word_ready[*2] ##1 o_word_ready; endproperty
    a_st3: assert property (p_st3) else $error("three cycle stall wrong");
    cover property (t1 && lone);
    cover property (o_exec_valid && o_busy && o_exec_cycles == 2'h3);
    cover property (o_exec_valid && !o_busy && o_exec_cycles == 2'h2);
endmodule
`default_nettype wire

/* test/ict_prog_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// ==============================
// Program memory offering queued words
module ict_prog_mem (
    input  wire logic   i_clk,
    input  wire logic   i_ready,
    output logic        o_valid,
    output logic [31:0] o_fetch
);
    logic [31:0] pend[$]; // Bit 31 asks for one idle cycle first
    logic        taken;   // Offer accepted at this edge
    initial begin
        o_valid = 1'b0;
        o_fetch = 32'h0;
    end
    // Offer held until taken; idle bus toggles so stale data never matches
    always @(posedge i_clk) begin
        taken = o_valid && i_ready;
        if (taken) begin
            void'(pend.pop_front());
        end
        #1;
        if (taken || !o_valid) begin
            o_valid = pend.size() > 0 && !pend[0][31];
            o_fetch = o_valid ? pend[0] : ~o_fetch;
            if (pend.size() > 0) begin
                pend[0][31] = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* test/instruction_cycle_timing_test.sv */
`timescale 1ns/10ps
`default_nettype none
module instruction_cycle_timing_test;
    import ict_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        valid, ready, ev, nop, busy;
    logic [31:0] f;
    logic [47:0] bits;
    logic [1:0]  cyc;
    logic [50:0] expq[$]; // Expected {nop, cycles, bits}
    int          mismatches = 0;
    int          total_checks = 0;
    int          seed = 50410;
    always #4 i_clk = ~i_clk;
    ict_prog_mem u_mem (.i_clk(i_clk), .i_ready(ready), .o_valid(valid), .o_fetch(f));
    ict_cycle_ctrl u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_word_valid(valid), .i_word(f[23:0]),
        .i_cls(ict_cls_type'(f[26:24])), .i_cond_true(f[27]), .i_pc_change(f[28]), .i_long_form(f[29]),
        .i_next_double(f[30]), .o_word_ready(ready), .o_exec_valid(ev), .o_exec_bits(bits),
        .o_exec_nop(nop), .o_exec_cycles(cyc), .o_busy(busy));
    task automatic chk(input string what, input logic [50:0] exp, input logic [50:0] got);
        total_checks++;
        if (exp !== got) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ==============================
    // Random stream with its expected results
    task automatic gen(input int n);
        logic [31:0] r;
        logic [23:0] w;
        logic [1:0]  c;
        repeat (n) begin
            r = $random(seed);
            w = 24'($random(seed));
            if (r[26:24] == 3'h7) r[26:24] = 3'h0;
            if (r[3:0] == 4'h0) w[23:16] = 8'h00;
            else if (w[23:16] == 8'h00) w[23:16] = 8'h5a;
            case (r[26:24])
                3'h0: c = (r[27] | r[28]) ? 2'h2 : 2'h1;
                3'h4: c = !r[27] ? 2'h1 : r[30] ? 2'h3 : 2'h2;
                default: c = r[29] ? 2'h3 : 2'h2;
            endcase
            u_mem.pend.push_back({r[31:24], w});
            if (w[23:16] == 8'h00) expq.push_back({1'b1, 2'h1, 48'h0});
            else if (r[26:24] inside {3'h5, 3'h6}) begin
                u_mem.pend.push_back({r[23:16], 8'h00, r[15:0]});
                expq.push_back({1'b0, 2'h2, w, 8'h00, r[15:0]});
            end else expq.push_back({1'b0, c, 24'h0, w});
        end
    endtask
    // Each completion against the model
    always @(negedge i_clk) begin
        if (ev === 1'b1) begin
            chk("exec", expq.size() > 0 ? expq.pop_front() : 51'h0, {nop, cyc, bits});
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        gen(400);
        for (int i = 0; i < 4000 && expq.size() > 0; i++) @(posedge i_clk);
        chk("left", 51'h0, 51'(expq.size()));
        final_report();
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
endmodule
bind ict_cycle_ctrl ict_checks u_chk (.i_clk, .i_nrst, .i_word_valid, .i_word, .i_cls, .i_cond_true,
    .i_pc_change, .i_long_form, .i_next_double, .o_word_ready, .o_exec_valid, .o_exec_bits, .o_exec_nop,
    .o_exec_cycles, .o_busy);
`default_nettype wire
